// file: csasm_pkg.sv
// package: constants and carriers for the cap-sense accumulate/scan block
package csasm_pkg;
  localparam int unsigned RES_W       = 16;
  localparam int unsigned SUM_W       = 22;
  localparam int unsigned CH_W        = 6;
  localparam logic [2:0]  ACC_1       = 3'h0;
  localparam logic [2:0]  ACC_4       = 3'h1;
  localparam logic [2:0]  ACC_8       = 3'h2;
  localparam logic [2:0]  ACC_16      = 3'h3;
  localparam logic [2:0]  ACC_32      = 3'h4;
  localparam logic [2:0]  ACC_64      = 3'h5;
  localparam logic [2:0]  MODE_BUSY   = 3'h0;
  localparam logic [2:0]  MODE_CONT   = 3'h6;
  localparam logic [2:0]  MODE_SCAN   = 3'h7;
  localparam logic [1:0]  RETRY_ALL   = 2'h0;
  localparam logic [1:0]  RETRY_TWO   = 2'h1;
  localparam logic [1:0]  RETRY_FOUR  = 2'h2;
  localparam logic [2:0]  RETRY_CAP2  = 3'h2;
  localparam logic [2:0]  RETRY_CAP4  = 3'h4;
  localparam logic [CH_W-1:0] CH_RST  = 6'h00;
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;

  typedef struct packed {
    logic twowire_watch_en;
    logic portwrite_watch_en;
    logic serial_periph_watch_en;
    logic [1:0] retry_limit_sel;
  } csasm_pin_watch_ctrl_t;

  typedef struct packed {
    logic twowire;
    logic portwrite;
    logic serial_periph;
  } csasm_pin_act_t;
endpackage

// file: csasm_retry.sv
// pin-monitor retry decision for one conversion portion
`timescale 1ns/1ns
module csasm_retry
  import csasm_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  ce_in,
  input  wire csasm_pin_watch_ctrl_t ctrl_in,
  input  wire csasm_pin_act_t        act_in,
  input  wire logic                  portion_end_in,
  input  wire logic                  conv_start_in,
  output logic                       retry_out
);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  wire        hit;
  wire        capped;
  // only enabled monitors may trigger; a disabled one costs nothing
  assign hit = (ctrl_in.twowire_watch_en & act_in.twowire) |
               (ctrl_in.portwrite_watch_en & act_in.portwrite) |
               (ctrl_in.serial_periph_watch_en & act_in.serial_periph);
  // capping guarantees completion under heavy switching
  assign capped = (ctrl_in.retry_limit_sel == RETRY_TWO  &&
                   cnt_reg >= RETRY_CAP2) ||
                  (ctrl_in.retry_limit_sel == RETRY_FOUR &&
                   cnt_reg >= RETRY_CAP4);              // see RULE8
  assign retry_out = portion_end_in & hit & ~capped;    // see RULE7
  assign cnt_next = conv_start_in ? 3'h0 :
                    (retry_out && cnt_reg != 3'h7) ? cnt_reg + 3'h1 :
                    cnt_reg;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= 3'h0;
    end else if (ce_in) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// file: csasm_top.sv
// accumulate, average, compare and auto-scan control for cap sensing
`timescale 1ns/1ns
//
// Contract
// RULE1 - sum 1,4,8,16,32 or 64 conversions
// RULE2 - divide sum by count, load result
// RULE3 - single mode: flags per conversion, channel kept
// RULE4 - accumulate: done after M, compare average
// RULE5 - scan: halt on greater, else step and wrap
// RULE6 - scan single: each conversion flags and compares
// RULE7 - enabled monitor repeats possibly corrupted portion
// RULE8 - retries unlimited at reset, else cap two/four
// RULE9 - retry event flag sticky until cleared
// RULE10 - three monitor enables, all off at reset
// RULE11 - software enables monitors only for heavy loads
// RULE12 - count field encodes 1 to 64 samples
// RULE13 - mode 111 scans continuously after busy write
// RULE14 - greater flag set above, cleared at or below
// RULE15 - divide is a right shift by log2 of count
module csasm_top
  import csasm_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  ce_in,
  input  wire logic [2:0]            accum_count_sel_in,
  input  wire logic [2:0]            start_mode_sel_in,
  input  wire logic                  busy_set_in,
  input  wire logic                  cmp_en_in,
  input  wire logic [RES_W-1:0]      threshold_in,
  input  wire logic [CH_W-1:0]       scan_start_channel_in,
  input  wire logic                  scan_start_wr_in,
  input  wire logic [CH_W-1:0]       scan_end_channel_in,
  input  wire logic [CH_W-1:0]       channel_select_wdata_in,
  input  wire logic                  channel_select_wr_in,
  input  wire csasm_pin_watch_ctrl_t pin_watch_ctrl_in,
  input  wire csasm_pin_act_t        pin_act_in,
  input  wire logic                  portion_end_in,
  input  wire logic                  conv_valid_in,
  input  wire logic [RES_W-1:0]      conv_data_in,
  input  wire logic                  done_clr_in,
  input  wire logic                  gt_clr_in,
  input  wire logic                  retry_evt_clr_in,
  output logic                       conv_start_out,
  output logic                       portion_retry_out,
  output logic                       conv_busy_out,
  output logic [CH_W-1:0]            channel_select_out,
  output logic [7:0]                 result_data_high_out,
  output logic [7:0]                 result_data_low_out,
  output logic                       conv_done_flag_out,
  output logic                       greater_than_flag_out,
  output logic                       retry_event_flag_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_CONV} csasm_state_t;

  csasm_state_t     state_reg;
  csasm_state_t     state_next;
  logic [SUM_W-1:0] sum_reg;
  logic [SUM_W-1:0] sum_next;
  logic [6:0]       cnt_reg;
  logic [6:0]       cnt_next;
  logic [RES_W-1:0] res_reg;
  logic [RES_W-1:0] res_next;
  logic [CH_W-1:0]  ch_reg;
  logic [CH_W-1:0]  ch_next;
  logic             done_reg;
  logic             gt_reg;
  logic             pme_reg;
  logic             start_reg;
  logic             retry_reg;
  logic             retry_w;
  logic             busy_reg;

  wire [6:0]        target;
  wire [2:0]        shamt;
  wire [SUM_W-1:0]  sum_add;
  wire [SUM_W-1:0]  avg;
  wire              last;
  wire              finish;
  wire              is_gt;
  wire              cont;
  wire              scan;
  wire              halt;
  wire [CH_W-1:0]   ch_step;
  wire              done_next;
  wire              gt_next;
  wire              pme_next;

  assign shamt  = (accum_count_sel_in == ACC_4)  ? 3'h2 :
                  (accum_count_sel_in == ACC_8)  ? 3'h3 :
                  (accum_count_sel_in == ACC_16) ? 3'h4 :
                  (accum_count_sel_in == ACC_32) ? 3'h5 :
                  (accum_count_sel_in == ACC_64) ? 3'h6 :
                  3'h0;                                  // see RULE12
  // reserved codes fall back to one sample
  assign target  = (shamt == 3'h0) ? 7'h01 : 7'(7'h01 << shamt);
  assign sum_add = sum_reg + SUM_W'(conv_data_in);       // see RULE1
  assign avg     = sum_add >> shamt;                     // see RULE15
  assign last    = (cnt_reg + 7'h01) >= target;
  assign finish  = (state_reg == ST_CONV) && conv_valid_in && last;
  // compare against the average, never the raw sum
  assign is_gt   = cmp_en_in &&
                   (avg[RES_W-1:0] > threshold_in);     // see RULE4
  assign scan    = (start_mode_sel_in == MODE_SCAN);
  assign cont    = scan || (start_mode_sel_in == MODE_CONT); // see RULE13
  assign halt    = scan && is_gt;                        // see RULE5
  assign ch_step = (ch_reg == scan_end_channel_in) ?
                   scan_start_channel_in : ch_reg + 6'h01;

  always_comb begin
    state_next = state_reg;
    sum_next   = sum_reg;
    cnt_next   = cnt_reg;
    res_next   = res_reg;
    ch_next    = ch_reg;
    if (channel_select_wr_in) begin
      ch_next = channel_select_wdata_in;
    end
    if (scan_start_wr_in && scan) begin
      ch_next = scan_start_channel_in;
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (busy_set_in) begin
          state_next = ST_START;
          sum_next   = '0;
          cnt_next   = 7'h00;
        end
      end
      ST_START: begin
        state_next = ST_CONV;
      end
      ST_CONV: begin
        if (conv_valid_in) begin
          if (last) begin
            res_next = avg[RES_W-1:0];                   // see RULE2
            sum_next = '0;
            cnt_next = 7'h00;
            // a greater-than in scan waits for a fresh busy write
            state_next = (cont && !halt) ? ST_START : ST_IDLE; // see RULE6
            if (scan && !is_gt) begin
              ch_next = ch_step;                         // see RULE5
            end
          end else begin
            sum_next   = sum_add;
            cnt_next   = cnt_reg + 7'h01;
            state_next = ST_START;
          end
        end
      end
    endcase
  end

  csasm_retry u_retry (
    .clk_in         (clk_in),
    .arst_n_in      (arst_n_in),
    .ce_in          (ce_in),
    .ctrl_in        (pin_watch_ctrl_in),
    .act_in         (pin_act_in),
    .portion_end_in (portion_end_in && state_reg == ST_CONV),
    .conv_start_in  (state_reg == ST_START),
    .retry_out      (retry_w)
  );                                                     // see RULE10

  // set beats clear on every flag, so no event is lost to a clear
  assign done_next = finish | (done_reg & ~done_clr_in);      // see RULE3
  // gt keeps its value while the comparator is off
  assign gt_next   = (finish && cmp_en_in) ? is_gt :
                     (gt_reg & ~gt_clr_in);                    // see RULE14
  assign pme_next  = retry_w | (pme_reg & ~retry_evt_clr_in);  // see RULE9

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= ST_IDLE;
      sum_reg   <= '0;
      cnt_reg   <= 7'h00;
      res_reg   <= RES_RST;
      ch_reg    <= CH_RST;
    end else if (ce_in) begin
      state_reg <= state_next;
      sum_reg   <= sum_next;
      cnt_reg   <= cnt_next;
      res_reg   <= res_next;
      ch_reg    <= ch_next;
    end
  end

  // busy comes from the next state so it lines up with state_reg
  // while still leaving the pin straight from a flip-flop
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_reg <= 1'b0;
      retry_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end else if (ce_in) begin
      start_reg <= (state_next == ST_START);
      retry_reg <= retry_w;
      busy_reg  <= (state_next != ST_IDLE);
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_reg <= 1'b0;
      gt_reg   <= 1'b0;
      pme_reg  <= 1'b0;
    end else if (ce_in) begin
      done_reg <= done_next;
      gt_reg   <= gt_next;
      pme_reg  <= pme_next;
    end
  end

  assign conv_start_out        = start_reg;
  assign portion_retry_out     = retry_reg;
  assign conv_busy_out         = busy_reg;
  assign channel_select_out    = ch_reg;
  assign result_data_high_out  = res_reg[15:8];
  assign result_data_low_out   = res_reg[7:0];
  assign conv_done_flag_out    = done_reg;
  assign greater_than_flag_out = gt_reg;
  assign retry_event_flag_out  = pme_reg;
endmodule

// file: csasm_checker.sv
// assertion checker bound to the cap-sense accumulate/scan top
`timescale 1ns/1ns
module csasm_checker
  import csasm_pkg::*;
(
  input wire logic                  clk_in,
  input wire logic                  arst_n_in,
  input wire logic                  ce_in,
  input wire logic                  busy_set_in,
  input wire logic [2:0]            start_mode_sel_in,
  input wire logic                  channel_select_wr_in,
  input wire csasm_pin_watch_ctrl_t pin_watch_ctrl_in,
  input wire csasm_pin_act_t        pin_act_in,
  input wire logic                  portion_end_in,
  input wire logic                  retry_evt_clr_in,
  input wire logic                  conv_start_out,
  input wire logic                  portion_retry_out,
  input wire logic                  conv_busy_out,
  input wire logic [CH_W-1:0]       channel_select_out,
  input wire logic                  greater_than_flag_out,
  input wire logic                  retry_event_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // retries of the running conversion; 8 bits and unsaturated, so unlimited mode wraps after 256 retries
  logic [7:0] n_retry_reg;
  logic [7:0] cap;
  assign cap = pin_watch_ctrl_in.retry_limit_sel == RETRY_TWO ? 8'h02 :
               pin_watch_ctrl_in.retry_limit_sel == RETRY_FOUR ? 8'h04 : 8'hff;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) n_retry_reg <= 8'h00;
    else if (conv_start_out) n_retry_reg <= 8'h00;
    else if (portion_retry_out) n_retry_reg <= n_retry_reg + 8'h01;
  end
  sequence start_seq;
    conv_busy_out && conv_start_out;
  endsequence
  busy_start_a: assert property (
    busy_set_in && ce_in && !conv_busy_out |=> start_seq)
    else $error("start request not followed by busy and start");
  retry_all_a: assert property (
    portion_end_in && conv_busy_out && |(pin_act_in & pin_watch_ctrl_in[4:2])
    && pin_watch_ctrl_in.retry_limit_sel == RETRY_ALL |=> portion_retry_out)
    else $error("watched activity did not repeat the portion");
  no_retry_a: assert property (
    !portion_end_in |=> !portion_retry_out)
    else $error("retry without a portion end");
  retry_cap_a: assert property (
    portion_retry_out |-> n_retry_reg < cap)
    else $error("retry count above the selected cap");
  evt_set_a: assert property (
    portion_retry_out && !retry_evt_clr_in ##1 !retry_evt_clr_in
    |-> retry_event_flag_out)
    else $error("retry event flag not set by a retry");
  evt_hold_a: assert property (
    retry_event_flag_out && !retry_evt_clr_in |=> retry_event_flag_out)
    else $error("retry event flag dropped without a clear");
  chan_hold_a: assert property (
    start_mode_sel_in != MODE_SCAN && !channel_select_wr_in
    |=> $stable(channel_select_out))
    else $error("channel moved outside scan mode");
  scan_halt_a: assert property (
    $rose(greater_than_flag_out) && start_mode_sel_in == MODE_SCAN
    |-> $stable(channel_select_out) ##1 !conv_busy_out)
    else $error("scan did not halt on greater result");
endmodule
bind csasm_top csasm_checker i_csasm_checker (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .ce_in(ce_in), .busy_set_in(busy_set_in),
  .start_mode_sel_in(start_mode_sel_in), .pin_act_in(pin_act_in),
  .channel_select_wr_in(channel_select_wr_in),
  .pin_watch_ctrl_in(pin_watch_ctrl_in), .portion_end_in(portion_end_in),
  .retry_evt_clr_in(retry_evt_clr_in), .conv_start_out(conv_start_out),
  .portion_retry_out(portion_retry_out), .conv_busy_out(conv_busy_out),
  .channel_select_out(channel_select_out),
  .greater_than_flag_out(greater_than_flag_out),
  .retry_event_flag_out(retry_event_flag_out));

// file: csasm_analog_model.sv
// behavioural converter front end answering the block's start pulses
`timescale 1ns/1ns
module csasm_analog_model
  import csasm_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             conv_start_in,
  input  wire logic             retry_in,
  input  wire logic [RES_W-1:0] raw_in,
  output logic                  portion_end_out,
  output logic                  conv_valid_out,
  output logic [RES_W-1:0]      conv_data_out
);
  int step = 0;
  initial {portion_end_out, conv_valid_out, conv_data_out} = 18'h0;
  // data toggles when not valid, so stale data is never trusted
  always @(posedge clk_in) begin
    portion_end_out <= 1'b0;
    conv_valid_out  <= 1'b0;
    conv_data_out   <= ~conv_data_out;
    if (conv_start_in) step <= 1;
    else if (step == 4) begin
      portion_end_out <= 1'b1;
      step            <= 5;
    end else if (step == 6 && retry_in) step <= 1;
    else if (step == 6) begin
      conv_valid_out <= 1'b1;
      conv_data_out  <= raw_in;
      step           <= 0;
    end else if (step != 0) step <= step + 1;
  end
endmodule

// file: csasm_top_tb.sv
// self-checking bench for the cap-sense accumulate/scan top
`timescale 1ns/1ns
module csasm_top_tb import csasm_pkg::*;;
  logic clk_in, arst_n_in, ce_in, busy_set_in, cmp_en_in, due, due2;
  logic scan_start_wr_in, channel_select_wr_in, portion_end_in, evt_seen;
  logic conv_valid_in, done_clr_in, gt_clr_in, retry_evt_clr_in, egt;
  logic conv_start_out, portion_retry_out, conv_busy_out;
  logic conv_done_flag_out, greater_than_flag_out, retry_event_flag_out;
  logic [2:0]       accum_count_sel_in, start_mode_sel_in;
  logic [RES_W-1:0] threshold_in, conv_data_in, raw;
  logic [CH_W-1:0]  scan_start_channel_in, scan_end_channel_in;
  logic [CH_W-1:0]  channel_select_wdata_in, channel_select_out;
  logic [7:0]       result_data_high_out, result_data_low_out;
  csasm_pin_watch_ctrl_t pin_watch_ctrl_in;
  csasm_pin_act_t        pin_act_in;
  int fail_count, n_compared, seed, cycles, sum, n, avg, ech;
  csasm_top i_csasm_top (.*);
  csasm_analog_model i_csasm_analog_model (.clk_in(clk_in),
    .conv_start_in(conv_start_out), .retry_in(portion_retry_out),
    .raw_in(raw), .portion_end_out(portion_end_in),
    .conv_valid_out(conv_valid_in), .conv_data_out(conv_data_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  function automatic int sh(input logic [2:0] a);
    return (a > 3'h5 || a == 3'h0) ? 0 : a + 1;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    @(negedge clk_in);
    while (due2 !== 1'b1 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    if (k == 3000) fail_count++;
  endtask
  task automatic start_busy;
    busy_set_in = 1'b1;
    @(negedge clk_in);
    busy_set_in = 1'b0;
  endtask
  task automatic clr_flags;
    {done_clr_in, gt_clr_in, retry_evt_clr_in} = 3'h7;
    evt_seen = 1'b0;
    @(negedge clk_in);
    {done_clr_in, gt_clr_in, retry_evt_clr_in} = 3'h0;
    check({conv_done_flag_out, greater_than_flag_out,
           retry_event_flag_out}, 0);
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  always @(posedge clk_in) begin
    due2 <= due;
    if (portion_retry_out) evt_seen = 1'b1;
    if (!arst_n_in) begin
      sum = 0;
      n   = 0;
    end
    if (conv_valid_in && conv_busy_out) begin
      sum += conv_data_in;
      n++;
    end
    due <= (n == (1 << sh(accum_count_sel_in)));
    if (n == (1 << sh(accum_count_sel_in))) begin
      avg = sum >> sh(accum_count_sel_in);
      // expectation frozen here so later threshold writes cannot race it
      egt = cmp_en_in && avg > threshold_in;
      sum = 0;
      n   = 0;
      if (start_mode_sel_in == MODE_SCAN && !egt)
        ech = (ech == scan_end_channel_in) ? scan_start_channel_in : ech + 1;
    end
  end
  always @(negedge clk_in) begin
    pin_act_in = (($random(seed) & 3) == 0) ? 3'($random(seed)) : 3'h0;
    raw = 16'($random(seed)) | 16'h0001;
    if (due2 === 1'b1) begin
      check({result_data_high_out, result_data_low_out}, avg);
      check(conv_done_flag_out, 1);
      check(greater_than_flag_out, egt);
      check(channel_select_out, ech);
    end
  end
  initial begin
    seed = 32'h955b97e9;
    {arst_n_in, busy_set_in, scan_start_wr_in, channel_select_wr_in,
     done_clr_in, gt_clr_in, retry_evt_clr_in, due, due2, evt_seen} = 10'h0;
    {accum_count_sel_in, start_mode_sel_in, threshold_in, raw} = 38'h0;
    {scan_start_channel_in, scan_end_channel_in} = 12'h0;
    channel_select_wdata_in = 6'h00;
    {pin_watch_ctrl_in, pin_act_in} = 8'h00;
    {ce_in, cmp_en_in} = 2'h3;
    repeat (8) @(negedge clk_in);
    arst_n_in = 1'b1;
    check({conv_busy_out, channel_select_out, result_data_high_out,
           result_data_low_out, retry_event_flag_out}, 0);
    for (int k = 0; k < 8; k++) begin
      accum_count_sel_in = 3'(k);
      pin_watch_ctrl_in = {3'($random(seed)), 2'(k)};
      threshold_in = 16'($random(seed));
      cmp_en_in = 1'($random(seed));
      start_busy();
      repeat (6) @(negedge clk_in);
      check({conv_busy_out, conv_done_flag_out}, 2);
      wait_done();
      check(retry_event_flag_out, evt_seen);
      clr_flags();
    end
    start_mode_sel_in = MODE_CONT;
    cmp_en_in = 1'b1;
    channel_select_wdata_in = 6'($random(seed));
    channel_select_wr_in = 1'b1;
    ech = channel_select_wdata_in;
    @(negedge clk_in);
    channel_select_wr_in = 1'b0;
    check(channel_select_out, ech);
    start_busy();
    repeat (3) wait_done();
    start_mode_sel_in = MODE_BUSY;
    wait_done();
    repeat (3) @(negedge clk_in);
    check(conv_busy_out, 0);
    start_mode_sel_in = MODE_SCAN;
    scan_start_channel_in = 6'h02;
    scan_end_channel_in = 6'h04;
    scan_start_wr_in = 1'b1;
    ech = 2;
    @(negedge clk_in);
    scan_start_wr_in = 1'b0;
    check(channel_select_out, ech);
    for (int j = 0; j < 2; j++) begin
      accum_count_sel_in = 3'(j);
      threshold_in = 16'hffff;
      start_busy();
      repeat (4) wait_done();
      threshold_in = 16'h0000;
      wait_done();
      repeat (3) @(negedge clk_in);
      check(conv_busy_out, 0);
      clr_flags();
    end
    // reset in mid-conversion must clear results, channel and flags
    start_mode_sel_in = MODE_BUSY;
    accum_count_sel_in = ACC_64;
    start_busy();
    repeat (40) @(negedge clk_in);
    arst_n_in = 1'b0;
    @(negedge clk_in);
    check({conv_busy_out, channel_select_out, result_data_high_out,
           result_data_low_out, conv_done_flag_out, greater_than_flag_out,
           retry_event_flag_out}, 0);
    arst_n_in = 1'b1;
    repeat (10) @(negedge clk_in);
    check(conv_busy_out, 0);
    give_verdict();
  end
endmodule
